/* core/dac_port_cfg.svh */
// Constants of the quad converter serial write port: offsets, fields, resets.
// Assumes inclusion from the package, the top module, the checker and the testbench.
`ifndef DAC_PORT_CFG_SVH
`define DAC_PORT_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses).
`define OFS_CTRL 4'h0
`define OFS_CODES 4'h4
`define OFS_STATUS 4'h8

// ==========================================================================
// Frame word layout.
`define WORD_BITS 16
`define FLD_CHAN_HI 15
`define FLD_CHAN_LO 14
`define FLD_MODE_HI 13
`define FLD_MODE_LO 12
`define FLD_DATA_HI 11
`define FLD_DATA_LO 4
`define LAST_BIT_CNT 5'h0F

// ==========================================================================
// Reset values.
`define RST_CTRL_EN 1'b1
`define RST_CODE 8'h00

`endif

/* core/dac_port_pkg.sv */
// Types of the quad converter serial write port.
// Assumes the constants header is on the include path.
`include "dac_port_cfg.svh"

package dac_port_pkg;

   // =======================================================================
   // Frame state and update modes.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } link_state_t;

   typedef enum logic [1:0] {
      MODE_LOAD = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_ALL = 2'b10,
      MODE_PDOWN = 2'b11
   } upd_mode_t;

   // =======================================================================
   // Whole state of the port.
   typedef struct packed {
      logic sclk_meta;
      logic sclk_s;
      logic sclk_prev;
      logic sync_meta;
      logic sync_s;
      logic din_meta;
      logic din_s;
      link_state_t st;
      logic [4:0] cnt;
      logic [15:0] shreg;
      logic [3:0][7:0] hold;
      logic [3:0][7:0] outc;
      logic pd;
      logic [1:0] term;
      logic enable;
      logic [7:0] aborts;
      logic written;
      logic ap_write;
      logic ap_valid;
      logic [3:0] ap_addr;
      logic [31:0] rdata;
   } port_state_t;

endpackage : dac_port_pkg

/* core/quad_dac_serial_write_port.sv */
// Serial write port and update control of a quad 8-bit converter.
// Assumes the link pins are asynchronous to hclk and that one AHB-Lite master
// reaches the registers.
//
// Function
// R1 - Shift data in on sclk falling edges
// R2 - Shift only while frame sync low
// R3 - Apply word on sixteenth falling edge
// R4 - Early frame sync rise discards word
// R5 - Outputs zero until first valid write
// R6 - Word carries channel, mode, powerdown, data
// R7 - Two mode bits: simultaneous or single update
// R8 - Power-down with three termination choices
// R9 - Host serial clock at most 40 MHz
// R10 - Host sends exactly sixteen bits per frame
`timescale 1ns/100ps
`include "dac_port_cfg.svh"

module quad_dac_serial_write_port
   import dac_port_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic din,
   output logic [7:0] channel_a_output,
   output logic [7:0] channel_b_output,
   output logic [7:0] channel_c_output,
   output logic [7:0] channel_d_output,
   output logic power_down,
   output logic [1:0] pd_termination
);

   // =======================================================================
   // State registers.
   port_state_t s_reg;
   port_state_t s_next;
   logic [15:0] word;
   logic [1:0] chan;
   upd_mode_t mode;
   logic [7:0] code;
   logic sclk_fall;
   logic bus_take;
   logic in_range;

   always_comb
   begin
      s_next = s_reg;

      // =====================================================================
      // Fields of the word that the current fall completes.
      word = {s_reg.shreg[14:0], s_reg.din_s};
      chan = word[`FLD_CHAN_HI:`FLD_CHAN_LO];
      mode = upd_mode_t'(word[`FLD_MODE_HI:`FLD_MODE_LO]);
      code = word[`FLD_DATA_HI:`FLD_DATA_LO];
      sclk_fall = s_reg.sclk_prev & ~s_reg.sclk_s;

      // =====================================================================
      // Two-flop synchronisers on the link pins.
      s_next.sclk_meta = sclk;
      s_next.sclk_s = s_reg.sclk_meta;
      s_next.sclk_prev = s_reg.sclk_s;
      s_next.sync_meta = sync_n;
      s_next.sync_s = s_reg.sync_meta;
      s_next.din_meta = din;
      s_next.din_s = s_reg.din_meta;

      // =====================================================================
      // Frame reception.
      case (s_reg.st)
         ST_IDLE:
         begin
            if (!s_reg.sync_s && s_reg.enable)
            begin
               s_next.st = ST_SHIFT; // R2
               s_next.cnt = 5'h00;
            end
         end
         ST_SHIFT:
         begin
            if (s_reg.sync_s)
            begin
               s_next.st = ST_IDLE; // R4
               s_next.aborts = s_reg.aborts + 8'h01;
            end
            else if (sclk_fall)
            begin
               s_next.shreg = word; // R1
               s_next.cnt = s_reg.cnt + 5'h01;
               if (s_reg.cnt == `LAST_BIT_CNT)
               begin
                  s_next.st = ST_DONE; // R3
                  s_next.written = 1'b1;
                  case (mode) // R6 R7
                     MODE_LOAD:
                     begin
                        s_next.hold[chan] = code;
                     end
                     MODE_SINGLE:
                     begin
                        s_next.hold[chan] = code;
                        s_next.outc[chan] = code;
                        s_next.pd = 1'b0;
                     end
                     MODE_ALL:
                     begin
                        s_next.hold[chan] = code;
                        s_next.outc = s_next.hold;
                        s_next.pd = 1'b0;
                     end
                     MODE_PDOWN:
                     begin
                        s_next.pd = 1'b1; // R8
                        s_next.term = chan;
                     end
                     default:
                     begin
                        s_next.pd = s_reg.pd;
                     end
                  endcase
               end
            end
         end
         ST_DONE:
         begin
            if (s_reg.sync_s)
            begin
               s_next.st = ST_IDLE; // R2
            end
         end
         default:
         begin
            s_next.st = ST_IDLE;
         end
      endcase

      // =====================================================================
      // AHB-Lite slave, zero wait states; only the low sixteen bytes decode.
      bus_take = hsel & hready & htrans[1];
      in_range = (haddr[31:4] == 28'h0000000);

      // =====================================================================
      // Register write in the data phase.
      if (s_reg.ap_valid && s_reg.ap_write && s_reg.ap_addr == `OFS_CTRL)
      begin
         s_next.enable = hwdata[0];
      end
      s_next.ap_valid = bus_take & in_range;
      s_next.ap_write = hwrite;
      s_next.ap_addr = haddr[3:0];

      // =====================================================================
      // Read data for the next data phase.
      s_next.rdata = 32'h00000000;
      if (bus_take && in_range && !hwrite)
      begin
         if (haddr[3:0] == `OFS_CTRL)
         begin
            s_next.rdata = {31'h00000000, s_next.enable};
         end
         else if (haddr[3:0] == `OFS_CODES)
         begin
            s_next.rdata = s_reg.outc;
         end
         else if (haddr[3:0] == `OFS_STATUS)
         begin
            s_next.rdata = {16'h0000, s_reg.aborts, 4'h0, s_reg.written, s_reg.term, s_reg.pd};
         end
         else
         begin
            s_next.rdata = 32'h00000000;
         end
      end
   end

   // =======================================================================
   // State register.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_reg <= '0;
         s_reg.sclk_meta <= 1'b1;
         s_reg.sclk_s <= 1'b1;
         s_reg.sclk_prev <= 1'b1;
         s_reg.sync_meta <= 1'b1;
         s_reg.sync_s <= 1'b1;
         s_reg.st <= ST_IDLE;
         s_reg.enable <= `RST_CTRL_EN;
         s_reg.outc <= {4{`RST_CODE}}; // R5
         s_reg.hold <= {4{`RST_CODE}};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // =======================================================================
   // Outputs.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign channel_a_output = s_reg.outc[0];
   assign channel_b_output = s_reg.outc[1];
   assign channel_c_output = s_reg.outc[2];
   assign channel_d_output = s_reg.outc[3];
   assign power_down = s_reg.pd;
   assign pd_termination = s_reg.term;

endmodule : quad_dac_serial_write_port

/* verif/serial_host_model.sv */
// Host serial controller model driving the link pins of the converter port.
// Assumes one caller at a time; the link clock stands still between frames.
`timescale 1ns/100ps
module serial_host_model
(
   output logic sync_n,
   output logic sclk,
   output logic din
);
   initial
   begin
      sync_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // =======================================================================
   // Sends the first n bits of w, MSB first, at a 200 ns period.
   task automatic send(input logic [15:0] w, input int n);
      #7 sync_n = 1'b0;
      #100;
      for (int i = 15; i > 15 - n; i--)
      begin
         din = w[i];
         #100 sclk = 1'b0;
         #100 sclk = 1'b1;
      end
      #100 sync_n = 1'b1;
      din = ~din;
      #200;
   endtask : send
endmodule : serial_host_model

/* verif/quad_dac_checker.sv */
// Checker of the quad converter serial write port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`include "dac_port_cfg.svh"
module quad_dac_checker
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic [7:0] channel_a_output,
   input wire logic [7:0] channel_b_output,
   input wire logic [7:0] channel_c_output,
   input wire logic [7:0] channel_d_output,
   input wire logic power_down
);
   logic [31:0] codes;
   assign codes = {channel_d_output, channel_c_output, channel_b_output, channel_a_output};
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // =======================================================================
   // Assertions.
   a_fall_gate: assert property (sclk [*8] |=> $stable(codes)) else $error("codes moved without a clock fall");
   a_sync_gate: assert property (sync_n [*8] |=> $stable(codes)) else $error("codes moved outside a frame");
   a_update_once: assert property ($changed(codes) |=> $stable(codes) [*4]) else $error("codes moved twice");
   a_zero_reset: assert property ($rose(hresetn) |-> codes == 32'h0) else $error("codes not zero after reset");
   a_codes_read: assert property (hsel && hready && htrans[1] && !hwrite && haddr == `OFS_CODES
      |=> hrdata == $past(codes)) else $error("codes read mismatch");
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_pd_keeps: assert property ($rose(power_down) |-> $stable(codes)) else $error("codes lost at power down");
   a_pd_quiet: assert property (sync_n [*8] |=> $stable(power_down)) else $error("power state moved idle");
   cover property ($rose(power_down));
   cover property ($changed(codes));
   cover property (hsel && htrans[1] && !hwrite);
endmodule : quad_dac_checker
bind quad_dac_serial_write_port quad_dac_checker i_quad_dac_checker (.*);

/* verif/tb_top.sv */
// Testbench of the quad converter serial write port.
// Assumes the constants header is on the include path.
`timescale 1ns/100ps
`include "dac_port_cfg.svh"
module tb_top;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sync_n, sclk, din, power_down;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, pd_termination;
   logic [2:0] hsize;
   logic [7:0] channel_a_output, channel_b_output, channel_c_output, channel_d_output;
   int miscompares, n_tests;
   assign hready = hreadyout;
   quad_dac_serial_write_port i_quad_dac_serial_write_port (.*);
   serial_host_model i_serial_host_model (.sync_n(sync_n), .sclk(sclk), .din(din));
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // =======================================================================
   // Shared tasks.
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'b10};
      do @(posedge hclk); while (!hready);
      {htrans, hwdata} <= {2'b00, d};
      do @(posedge hclk); while (!hready);
      rd = hrdata;
      hsel <= 1'b0;
   endtask : ahb
   task automatic outs(input logic [31:0] e);
      ahb(1'b0, `OFS_CODES, 32'h0);
      chk(e, rd);
      chk(e, {channel_d_output, channel_c_output, channel_b_output, channel_a_output});
   endtask : outs
   task automatic frame(input logic [15:0] w, input int n);
      i_serial_host_model.send(w, n);
      repeat (8) @(posedge hclk);
   endtask : frame
   task end_sim;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   // =======================================================================
   // Scenarios.
   task automatic t_words;
      outs(32'h0);
      frame(16'h5A50, 16);
      outs(32'h0000A500);
      frame(16'h1FF0, 15);
      outs(32'h0000A500);
      ahb(1'b0, `OFS_STATUS, 32'h0);
      chk(32'h108, rd);
      frame(16'h83C0, 16);
      outs(32'h0000A500);
      frame(16'hE770, 16);
      outs(32'h773CA500);
      $display("word scenario done");
   endtask : t_words
   task automatic t_pdown;
      for (int t = 1; t < 4; t++)
      begin
         frame({t[1:0], 14'h3000}, 16);
         chk({1'b1, t[1:0]}, {power_down, pd_termination});
         outs(32'h773CA500);
      end
      ahb(1'b0, `OFS_STATUS, 32'h0);
      chk(32'h10F, rd);
      frame(16'h1220, 16);
      chk(32'h0, power_down);
      outs(32'h773CA522);
      $display("power down scenario done");
   endtask : t_pdown
   task automatic t_regs;
      ahb(1'b1, `OFS_CTRL, 32'h0);
      ahb(1'b1, `OFS_CODES, 32'hFFFFFFFF);
      frame(16'h1110, 16);
      outs(32'h773CA522);
      ahb(1'b0, `OFS_CTRL, 32'h0);
      chk(32'h0, rd);
      ahb(1'b1, `OFS_CTRL, 32'h1);
      ahb(1'b1, 32'h10, 32'h0);
      ahb(1'b0, 32'h10, 32'h0);
      chk(32'h0, rd);
      ahb(1'b0, `OFS_CTRL, 32'h0);
      chk(32'h1, rd);
      frame(16'h1110, 16);
      outs(32'h773CA511);
      $display("register scenario done");
   endtask : t_regs
   task automatic t_reset;
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      outs(32'h0);
      ahb(1'b0, `OFS_STATUS, 32'h0);
      chk(32'h0, rd);
      ahb(1'b0, `OFS_CTRL, 32'h0);
      chk(32'h1, rd);
      $display("reset scenario done");
   endtask : t_reset
   initial
   begin
      {hresetn, hsel, haddr, hwrite, htrans, hwdata, hsize} = {1'b0, 1'b0, 32'h0, 1'b0, 2'h0, 32'h0, 3'h2};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_words;
      t_pdown;
      t_regs;
      t_reset;
      end_sim;
   end
   initial
   begin
      #300us;
      miscompares++;
      end_sim;
   end
endmodule : tb_top
